//--- rtl/csp_pkg.sv
package csp_pkg;
  localparam int WORD_W = 16;
  localparam int PROD_W = 32;
  // status word a fields
  localparam int A_PTR_HI  = 15;
  localparam int A_PTR_LO  = 13;
  localparam int A_OVF     = 12;
  localparam int A_SAT     = 11;
  localparam int A_RSV     = 10;
  localparam int A_IRQDIS  = 9;
  localparam int A_PAGE_HI = 8;
  // status word b fields
  localparam int B_BAK_HI  = 15;
  localparam int B_BAK_LO  = 13;
  localparam int B_RAMMAP  = 12;
  localparam int B_TEST    = 11;
  localparam int B_SXM     = 10;
  localparam int B_CARRY   = 9;
  localparam int B_XF      = 4;
  localparam int B_PSEL_HI = 1;
  localparam logic [15:0] A_RSV_MASK = 16'h0400;
  localparam logic [15:0] B_RSV_MASK = 16'h01ec;
  // reset values: irq disable, carry and sign extend set; page, shift and ram map cleared
  localparam logic [15:0] A_RESET = 16'h0600;
  localparam logic [15:0] B_RESET = 16'h07fc;
  localparam logic [15:0] A_WRMASK = 16'hf9ff; // all but reserved and irq disable
  localparam logic [15:0] B_WRMASK = 16'hfe13;
  localparam int PAGE_W = 9;
  localparam int OFS_W  = 7;
  typedef enum logic [1:0] {
    SHIFT_NONE  = 2'b00,
    SHIFT_L1    = 2'b01,
    SHIFT_L4    = 2'b10,
    SHIFT_R6    = 2'b11
  } csp_shift_type;
endpackage

//--- rtl/csp_prod_if.sv
`timescale 1ns/10ps
interface csp_prod_if;
  logic [31:0]   product;
  csp_pkg::csp_shift_type sel;
  logic [31:0]   scaled;
  modport holder  (output product, output sel, input scaled);
  modport shifter (input product, input sel, output scaled);
endinterface

//--- rtl/csp_product_shifter.sv
`timescale 1ns/10ps
module csp_product_shifter
  import csp_pkg::*;
(
  csp_prod_if.shifter p
);
  always_comb begin
    unique case (p.sel)
      SHIFT_NONE: p.scaled = p.product;
      SHIFT_L1:   p.scaled = {p.product[30:0], 1'b0};
      SHIFT_L4:   p.scaled = {p.product[27:0], 4'h0};
      SHIFT_R6:   p.scaled = {{6{p.product[31]}}, p.product[31:6]};
    endcase
  end
endmodule // csp_product_shifter

//--- rtl/csp_status_regs.sv
`timescale 1ns/10ps
// What this block does
// - two 16-bit status words, saved to and restored from data memory
// - load-status writes a memory word into the chosen status word
// - load-status leaves the global interrupt disable bit untouched
// - store-status copies the chosen status word onto the memory bus
// - bit-set and bit-clear force one status bit to one or zero
// - reserved bits always read as one
// - word a: pointer, overflow, saturate, irq disable, page pointer
// - word b: backup, ram map, test, sign extend, carry, flag, shift select
// - product shifter: none, left one, left four, right six
// - product shifter is combinational, no added cycles
// - 32-bit product register holds each 16x16 product
// - operand register feeds multiplier, shift count and bit position
// - shift select encoding 00,01,10,11; product register unchanged
// - loading the pointer copies old pointer to backup, not on load-status
// - irq disable set by reset and by taking a maskable interrupt
// - page pointer plus seven instruction bits form the direct address
module csp_status_regs
  import csp_pkg::*;
#(
  parameter int PTR_W = 3
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        loadStatus,
  input  wire logic        loadSel,
  input  wire logic [15:0] memData,
  input  wire logic        storeStatus,
  input  wire logic        storeSel,
  output logic      [15:0] storeData,
  input  wire logic        bitSet,
  input  wire logic        bitClear,
  input  wire logic        bitWord,
  input  wire logic [3:0]  bitIndex,
  input  wire logic        ptrLoad,
  input  wire logic [2:0]  ptrValue,
  input  wire logic        pageLoad,
  input  wire logic [8:0]  pageValue,
  input  wire logic        ovfEvent,
  input  wire logic        ovfClear,
  input  wire logic        carryLoad,
  input  wire logic        carryValue,
  input  wire logic        testLoad,
  input  wire logic        testValue,
  input  wire logic        shiftSelLoad,
  input  wire logic [1:0]  shiftSelValue,
  input  wire logic        irqTaken,
  input  wire logic        operandLoad,
  input  wire logic [15:0] operandValue,
  input  wire logic        multiplyDo,
  input  wire logic        multiplySigned,
  input  wire logic [15:0] multiplicand,
  input  wire logic [6:0]  insnOffset,
  output logic      [15:0] statusWordA,
  output logic      [15:0] statusWordB,
  output logic      [31:0] productHolding,
  output logic      [31:0] scaledProduct,
  output logic      [15:0] operandReg,
  output logic      [3:0]  dynShiftCount,
  output logic      [3:0]  dynBitPos,
  output logic      [15:0] directAddr,
  output logic             irqEnabled,
  output logic             extFlagOut,
  output logic             saturateMode,
  output logic             signExtendMode,
  output logic             ramMapSelect
);
  // refuse constants that the masking below cannot serve
  if (WORD_W != 16) begin : g_bad_word
    $error("ports are sized for 16-bit status words");
  end
  if (PTR_W != A_PTR_HI - A_PTR_LO + 1) begin : g_bad_ptr
    $error("pointer width must match its field");
  end
  if (PTR_W != B_BAK_HI - B_BAK_LO + 1) begin : g_bad_backup
    $error("backup width must match the pointer");
  end
  if (PAGE_W + OFS_W != WORD_W) begin : g_bad_addr
    $error("page and offset must fill one word");
  end
  if (PROD_W != 2 * WORD_W) begin : g_bad_prod
    $error("product must be twice the word width");
  end
  if ((A_WRMASK & A_RSV_MASK) != 16'h0000) begin : g_bad_mask_a
    $error("word a load mask covers reserved bits");
  end
  if (A_WRMASK[A_IRQDIS] != 1'b0) begin : g_bad_irq_mask
    $error("word a load mask covers irq disable");
  end
  if ((B_WRMASK & B_RSV_MASK) != 16'h0000) begin : g_bad_mask_b
    $error("word b load mask covers reserved bits");
  end
  if ((A_RESET & A_RSV_MASK) != A_RSV_MASK || !A_RESET[A_IRQDIS]) begin : g_bad_reset_a
    $error("word a reset must set reserved bits and irq disable");
  end
  if ((B_RESET & B_RSV_MASK) != B_RSV_MASK) begin : g_bad_reset_b
    $error("word b reset must set reserved bits");
  end

  typedef struct packed {
    logic [15:0] wordA;
    logic [15:0] wordB;
    logic [31:0] prod;
    logic [15:0] operand;
    logic [15:0] store;
  } csp_state_type;

  csp_state_type cur;
  csp_state_type next_cur;
  csp_prod_if    prodBus ();
  logic [31:0]   fullProduct;
  logic          loadWordA;
  logic          loadWordB;
  logic          ptrMove;
  logic          pageMove;
  logic [15:0]   bitHitA;
  logic [15:0]   bitHitB;
  logic [15:0]   bitFill;

  always_comb begin
    if (multiplySigned) begin
      fullProduct = 32'($signed(operandReg) * $signed(multiplicand));
    end else begin
      fullProduct = operandReg * multiplicand;
    end
  end

  assign loadWordA = loadStatus && !loadSel;
  assign loadWordB = loadStatus && loadSel;
  // the load owns the pointer in its cycle, so no backup copy then
  assign ptrMove   = ptrLoad && !loadStatus;
  assign pageMove  = pageLoad && !loadStatus;
  assign bitFill   = {WORD_W{bitSet}}; // set wins when both strobes are high

  // one select line per status bit, so a bit op cannot reach its neighbours
  for (genvar i = 0; i < WORD_W; i++) begin : g_bit_hit
    assign bitHitA[i] = (bitSet || bitClear) && !bitWord && bitIndex == 4'(i);
    assign bitHitB[i] = (bitSet || bitClear) && bitWord && bitIndex == 4'(i);
  end

  always_comb begin
    logic [15:0] a;
    logic [15:0] b;
    a = cur.wordA;
    b = cur.wordB;
    next_cur = cur;
    if (loadWordA)
      a = (memData & A_WRMASK) | (a & ~A_WRMASK);
    if (loadWordB) begin
      b = (memData & B_WRMASK) | (b & ~B_WRMASK);
      a[A_PTR_HI:A_PTR_LO] = memData[B_BAK_HI:B_BAK_LO]; // pointer follows loaded backup
    end
    if (ptrMove) begin
      b[B_BAK_HI:B_BAK_LO] = a[A_PTR_HI:A_PTR_LO];
      a[A_PTR_HI:A_PTR_LO] = ptrValue;
    end
    if (pageMove)
      a[A_PAGE_HI:0] = pageValue;
    if (ovfClear)
      a[A_OVF] = 1'b0;
    if (ovfEvent)
      a[A_OVF] = 1'b1; // set wins over clear
    if (carryLoad)
      b[B_CARRY] = carryValue;
    if (testLoad)
      b[B_TEST] = testValue;
    if (shiftSelLoad)
      b[B_PSEL_HI:0] = shiftSelValue;
    a = (a & ~bitHitA) | (bitFill & bitHitA);
    b = (b & ~bitHitB) | (bitFill & bitHitB);
    if (irqTaken)
      a[A_IRQDIS] = 1'b1;
    next_cur.wordA = a | A_RSV_MASK;
    next_cur.wordB = b | B_RSV_MASK;
    if (operandLoad)
      next_cur.operand = operandValue;
    if (multiplyDo)
      next_cur.prod = fullProduct;
    if (storeStatus)
      next_cur.store = storeSel ? (cur.wordB | B_RSV_MASK) : (cur.wordA | A_RSV_MASK);
  end

  // synchronous reset puts every field back at once
  always_ff @(posedge clk) begin
    if (rst) begin
      cur.wordA   <= A_RESET;
      cur.wordB   <= B_RESET;
      cur.prod    <= 32'h00000000;
      cur.operand <= 16'h0000;
      cur.store   <= 16'h0000;
    end else begin
      cur <= next_cur;
    end
  end

  assign prodBus.product = cur.prod;
  assign prodBus.sel     = csp_shift_type'(cur.wordB[B_PSEL_HI:0]);

  // combinational, so scaling costs no cycle
  csp_product_shifter u_shifter (
    .p (prodBus.shifter)
  );

  assign scaledProduct  = prodBus.scaled;
  // registered outputs, except irqEnabled is inverted and directAddr takes insnOffset straight from the input
  assign statusWordA    = cur.wordA;
  assign statusWordB    = cur.wordB;
  assign storeData      = cur.store;
  assign productHolding = cur.prod;
  assign operandReg     = cur.operand;
  assign dynShiftCount  = cur.operand[3:0];
  assign dynBitPos      = cur.operand[3:0];
  assign directAddr     = {cur.wordA[A_PAGE_HI:0], insnOffset};
  assign irqEnabled     = ~cur.wordA[A_IRQDIS];
  assign extFlagOut     = cur.wordB[B_XF];
  assign saturateMode   = cur.wordA[A_SAT];
  assign signExtendMode = cur.wordB[B_SXM];
  assign ramMapSelect   = cur.wordB[B_RAMMAP];
endmodule // csp_status_regs

//--- sim/csp_status_regs_assertions.sv
`timescale 1ns/10ps
module csp_status_regs_assertions
  import csp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        loadStatus,
  input wire logic        loadSel,
  input wire logic [15:0] memData,
  input wire logic        storeStatus,
  input wire logic        storeSel,
  input wire logic [15:0] storeData,
  input wire logic        bitSet,
  input wire logic        bitClear,
  input wire logic        bitWord,
  input wire logic [3:0]  bitIndex,
  input wire logic        ptrLoad,
  input wire logic [2:0]  ptrValue,
  input wire logic        irqTaken,
  input wire logic        ovfEvent,
  input wire logic        ovfClear,
  input wire logic        pageLoad,
  input wire logic [6:0]  insnOffset,
  input wire logic [15:0] statusWordA,
  input wire logic [15:0] statusWordB,
  input wire logic [31:0] productHolding,
  input wire logic [31:0] scaledProduct,
  input wire logic [15:0] directAddr,
  input wire logic        irqEnabled
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reserved_ones: assert property (
    (statusWordA & A_RSV_MASK) == A_RSV_MASK && (statusWordB & B_RSV_MASK) == B_RSV_MASK)
    else $error("reserved bit low");
  a_load_word_a: assert property (
    loadStatus && !loadSel && !bitSet && !bitClear && !irqTaken |=>
    {statusWordA[15:13], statusWordA[11:0]} == {$past(memData[15:13]), $past(memData[11]),
    1'h1, $past(statusWordA[9]), $past(memData[8:0])}) else $error("word a load wrong");
  a_store_copy: assert property (
    storeStatus |=> storeData == $past(storeSel ? statusWordB : statusWordA))
    else $error("stored word wrong");
  a_irq_taken: assert property (
    irqTaken |=> statusWordA[9] && !irqEnabled) else $error("irq disable not set");
  a_ptr_backup: assert property (
    ptrLoad && !loadStatus |=> statusWordA[15:13] == $past(ptrValue) &&
    statusWordB[15:13] == $past(statusWordA[15:13])) else $error("pointer backup wrong");
  a_shift_scale: assert property (
    scaledProduct == (statusWordB[1:0] == 2'h0 ? productHolding : statusWordB[1:0] == 2'h1 ?
    productHolding << 1 : statusWordB[1:0] == 2'h2 ? productHolding << 4 :
    32'($signed(productHolding) >>> 6))) else $error("scaled product wrong");
  a_direct_addr: assert property (
    directAddr == {statusWordA[8:0], insnOffset}) else $error("direct address wrong");
  a_bit_only: assert property (
    bitSet && !bitWord && !loadStatus && !ptrLoad && !irqTaken && !pageLoad && !ovfEvent &&
    !ovfClear |=> statusWordA == ($past(statusWordA) | (16'h1 << $past(bitIndex))))
    else $error("bit set spread");
  a_ovf_set_wins: assert property (
    ovfEvent |=> statusWordA[12]) else $error("overflow flag not set");
endmodule // csp_status_regs_assertions
bind csp_status_regs csp_status_regs_assertions csp_status_regs_assertions_i (.*);

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import csp_pkg::*;
  logic clk = 1'h0, rst = 1'h1, loadStatus = 1'h0, loadSel = 1'h0, storeStatus = 1'h0;
  logic storeSel = 1'h0, bitSet = 1'h0, bitClear = 1'h0, bitWord = 1'h0, ptrLoad = 1'h0;
  logic pageLoad = 1'h0, ovfEvent = 1'h0, ovfClear = 1'h0, carryLoad = 1'h0, carryValue = 1'h0;
  logic testLoad = 1'h0, testValue = 1'h0, shiftSelLoad = 1'h0, irqTaken = 1'h0;
  logic operandLoad = 1'h0, multiplyDo = 1'h0, multiplySigned = 1'h0;
  logic [15:0] memData = 16'h0, operandValue = 16'h0, multiplicand = 16'h0;
  logic [3:0]  bitIndex = 4'h0;
  logic [2:0]  ptrValue = 3'h0;
  logic [8:0]  pageValue = 9'h0;
  logic [1:0]  shiftSelValue = 2'h0;
  logic [6:0]  insnOffset = 7'h0;
  logic [15:0] storeData, statusWordA, statusWordB, operandReg, directAddr;
  logic [31:0] productHolding, scaledProduct;
  logic [3:0]  dynShiftCount, dynBitPos;
  logic        irqEnabled, extFlagOut, saturateMode, signExtendMode, ramMapSelect;
  int          err_count = 0, checks_done = 0, cycles = 0;
  csp_status_regs csp_status_regs_i (.*);
  always #50 clk = ~clk;
  task chk(string what, logic [31:0] seen, logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // generous: the whole sequence needs well under 100 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      err_count++;
      summarize();
    end
  end
  task t_load_store;
    @(posedge clk); bitClear <= 1'h1; bitIndex <= 4'h9;
    @(posedge clk); bitClear <= 1'h0; loadStatus <= 1'h1; memData <= 16'hfbff;
    @(posedge clk); loadStatus <= 1'h0; storeStatus <= 1'h1; #1;
    chk("wordA", statusWordA, 16'hfdff);
    chk("saturate", saturateMode, 1'h1);
    chk("noBackup", statusWordB, 16'h07fc);
    @(posedge clk); storeStatus <= 1'h0; loadStatus <= 1'h1; loadSel <= 1'h1;
    memData <= 16'h1000; #1;
    chk("stored", storeData, 16'hfdff);
    @(posedge clk); loadStatus <= 1'h0; bitSet <= 1'h1; bitWord <= 1'h1; bitIndex <= 4'h4; #1;
    chk("ptrFromB", statusWordA, 16'h1dff);
    chk("signExt", signExtendMode, 1'h0);
    chk("ramMap", ramMapSelect, 1'h1);
    @(posedge clk); bitSet <= 1'h0; #1;
    chk("wordB", statusWordB, 16'h11fc);
    chk("flag", extFlagOut, 1'h1);
    chk("irqOn", irqEnabled, 1'h1);
    @(posedge clk); bitClear <= 1'h1; bitWord <= 1'h0; bitIndex <= 4'hb;
    @(posedge clk); bitClear <= 1'h0; bitSet <= 1'h1; #1;
    chk("satClear", statusWordA, 16'h15ff);
    @(posedge clk); bitSet <= 1'h0; #1;
    chk("satSet", statusWordA, 16'h1dff);
  endtask
  task t_ovf;
    @(posedge clk); ovfClear <= 1'h1;
    @(posedge clk); ovfClear <= 1'h0; #1;
    chk("ovfClear", statusWordA[12], 1'h0);
    @(posedge clk); ovfClear <= 1'h1; ovfEvent <= 1'h1;
    @(posedge clk); ovfClear <= 1'h0; ovfEvent <= 1'h0; #1;
    chk("ovfSetWins", statusWordA[12], 1'h1);
  endtask
  task t_ptr_irq;
    @(posedge clk); ptrLoad <= 1'h1; ptrValue <= 3'h5;
    @(posedge clk); ptrValue <= 3'h2;
    @(posedge clk); ptrLoad <= 1'h0; irqTaken <= 1'h1;
    @(posedge clk); irqTaken <= 1'h0; #1;
    chk("ptr", statusWordA[15:13], 32'h2);
    chk("backup", statusWordB[15:13], 32'h5);
    chk("irqOff", irqEnabled, 1'h0);
  endtask
  task t_mult;
    logic [31:0] want [4] = '{32'hfffffffa, 32'hfffffff4, 32'hffffffa0, 32'hffffffff};
    @(posedge clk); operandLoad <= 1'h1; operandValue <= 16'hfffe; multiplicand <= 16'h3;
    @(posedge clk); operandLoad <= 1'h0; multiplyDo <= 1'h1; multiplySigned <= 1'h1;
    @(posedge clk); multiplyDo <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk); shiftSelLoad <= 1'h1; shiftSelValue <= 2'(i);
      @(posedge clk); shiftSelLoad <= 1'h0; #1;
      chk("scaled", scaledProduct, want[i]);
      chk("product", productHolding, 32'hfffffffa);
    end
    chk("shiftCount", dynShiftCount, 4'he);
    chk("bitPos", dynBitPos, 4'he);
    chk("operand", operandReg, 16'hfffe);
    @(posedge clk); multiplyDo <= 1'h1; multiplySigned <= 1'h0;
    @(posedge clk); multiplyDo <= 1'h0; #1;
    chk("unsigned", productHolding, 32'h0002fffa);
  endtask
  task t_page_flags;
    @(posedge clk); pageLoad <= 1'h1; pageValue <= 9'h1a5; insnOffset <= 7'h33;
    testLoad <= 1'h1; testValue <= 1'h1; carryLoad <= 1'h1; carryValue <= 1'h1;
    @(posedge clk); pageLoad <= 1'h0; testLoad <= 1'h0; carryLoad <= 1'h0; #1;
    chk("direct", directAddr, 16'hd2b3);
    chk("testCarry", statusWordB[11:9], 32'h5);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0; #1;
    chk("resetA", statusWordA, A_RESET);
    chk("resetB", statusWordB, B_RESET);
    t_load_store();
    t_ptr_irq();
    t_mult();
    t_page_flags();
    t_ovf();
    summarize();
  end
endmodule // tb_top
